// *** sdcd_cfg.svh ***
// constants for the sdram command decoder
`ifndef SDCD_CFG_SVH
`define SDCD_CFG_SVH
`define SDCD_BANKS 8
`define SDCD_BA_W 3
`define SDCD_ADDR_W 13
`define SDCD_COL_W 10
`define SDCD_AP_BIT 10
`define SDCD_BC_BIT 12
`define SDCD_DQ_W 16
`define SDCD_BEATS_BL8 4'h8
`define SDCD_BEATS_BC4 4'h4
`define SDCD_MR0_SEL 3'h0
`define SDCD_BL_BL8 2'h0
`define SDCD_BL_OTF 2'h1
`define SDCD_BL_BC4 2'h2
`endif

// *** sdcd_pkg.sv ***
// types shared by the sdram command decoder
package sdcd_pkg;
  typedef enum logic [3:0] {
    CMD_DESELECT = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACTIVATE = 4'h2,
    CMD_PRECHARGE = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_READ = 4'h5,
    CMD_MODE_SET = 4'h6,
    CMD_REFRESH = 4'h7,
    CMD_SELF_REF_ENTER = 4'h8,
    CMD_SELF_REF_EXIT = 4'h9,
    CMD_PDOWN_ENTER = 4'ha,
    CMD_PDOWN_EXIT = 4'hb,
    CMD_ZQ_LONG = 4'hc,
    CMD_ZQ_SHORT = 4'hd,
    CMD_ILLEGAL = 4'he
  } sdcd_cmd_type;
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_PDOWN = 2'b01,
    ST_SELF_REF = 2'b10
  } sdcd_pwr_type;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [2:0] ba;
    logic [12:0] addr;
  } sdcd_pins_type;
  typedef struct packed {
    sdcd_cmd_type cmd;
    logic [2:0] bank;
    logic [12:0] addr;
    logic auto_pre;
    logic [3:0] beats;
  } sdcd_dec_type;
endpackage : sdcd_pkg

// *** sdcd_decoder.sv ***
// sdram command decoder with bank state, burst framing and data masking
// What this block does
// - decode with chip select low, save power-down entry and the two exits, which also take deselect; chip select high is deselect; nop all high
// - precharge: ras low cas high we low; a10 picks one bank or all banks
// - write: ras high cas low we low to active bank; a12 chooses chop
// - read: ras high cas low we high to active bank; a12 chooses chop
// - a10 on read or write requests auto-precharge after the burst
// - a12 burst choice honoured only when on-the-fly mode is programmed
// - mode register write: all four strobes low while idle; bank lines select register
// - refresh with cke high; cke falling enters self-refresh; cke rising exits
// - power-down entered on cke falling with nop or deselect
// - power-down left on cke rising with nop or deselect
// - zq calibration: ras high cas high we low; a10 long or short
// - cke commands judge prior-cycle cke against command-cycle cke
// - lower and upper byte masks apply independently during writes
// - bank state checks use the bank addressed by the command
// - eight banks; each eight-beat access moves one 8n word over four clocks, a chopped one over two
// - pin data moves two words per clock
// - bursts start at the column and run eight or four beats
// - lower mask covers bits 0-7, upper mask bits 8-15
// - active-low reset holds the device in reset
`timescale 1ns/10ps
`default_nettype none
`include "sdcd_cfg.svh"
module sdcd_decoder
  import sdcd_pkg::*;
(
  input wire logic sys_clk, // 250 MHz clock
  input wire logic reset, // synchronous reset, active high
  input wire logic reset_pin_n, // device reset pin, active low
  input wire sdcd_pins_type pins, // command pins, sampled each rising edge
  input wire logic [1:0] wr_mask, // byte masks, bit1 upper
  input wire logic [31:0] wr_data_pair, // two pin words of one clock
  output sdcd_dec_type dec_q, // decoded command, registered
  output logic dec_valid_q, // decoded command pulse
  output logic [7:0] bank_open_q, // open-row state per bank
  output sdcd_pwr_type pwr_q, // power state
  output logic burst_busy_q, // burst in progress
  output logic burst_write_q, // burst is a write
  output logic [2:0] burst_bank_q, // bank of running burst
  output logic [9:0] burst_col_q, // current column of burst
  output logic [31:0] wdata_q, // write pair, unmasked; masking is in wbyte_en_q
  output logic [3:0] wbyte_en_q, // byte enables of wdata_q
  output logic wdata_valid_q // write pair valid
);
  // reset pin passes three flops; change taken when last two agree
  logic [2:0] rst_sync_q;
  logic rst_hold_q;
  logic dev_rst;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rst_sync_q <= 3'h0;
      rst_hold_q <= 1'b1;
    end else begin
      rst_sync_q <= {rst_sync_q[1:0], reset_pin_n};
      if (rst_sync_q[2] == rst_sync_q[1]) begin
        rst_hold_q <= ~rst_sync_q[2];
      end
    end
  end
  assign dev_rst = reset | rst_hold_q;

  // prior-cycle cke kept for comparison
  logic cke_prev_q;
  always_ff @(posedge sys_clk) begin
    if (dev_rst) begin
      cke_prev_q <= 1'b0;
    end else begin
      cke_prev_q <= pins.cke;
    end
  end

  // pattern classification
  logic idle_all;
  logic bank_act;
  logic nop_or_des;
  sdcd_cmd_type cmd;
  assign idle_all = (bank_open_q == 8'h00);
  assign bank_act = bank_open_q[pins.ba];
  assign nop_or_des = pins.cs_n | (pins.ras_n & pins.cas_n & pins.we_n);
  always_comb begin
    cmd = CMD_ILLEGAL;
    if (pwr_q != ST_NORMAL) begin
      if (!cke_prev_q && pins.cke && nop_or_des) begin
        cmd = (pwr_q == ST_SELF_REF) ? CMD_SELF_REF_EXIT : CMD_PDOWN_EXIT;
      end
    end else if (!cke_prev_q) begin
      cmd = CMD_ILLEGAL;
    end else if (!pins.cke) begin
      if (nop_or_des) begin
        cmd = CMD_PDOWN_ENTER;
      end else if ({pins.ras_n, pins.cas_n, pins.we_n} == 3'b001 && idle_all) begin
        cmd = CMD_SELF_REF_ENTER;
      end
    end else if (pins.cs_n) begin
      cmd = CMD_DESELECT;
    end else begin
      case ({pins.ras_n, pins.cas_n, pins.we_n})
        3'b111: cmd = CMD_NOP;
        3'b011: cmd = bank_act ? CMD_ILLEGAL : CMD_ACTIVATE;
        3'b010: cmd = CMD_PRECHARGE;
        3'b100: cmd = bank_act ? CMD_WRITE : CMD_ILLEGAL;
        3'b101: cmd = bank_act ? CMD_READ : CMD_ILLEGAL;
        3'b000: cmd = idle_all ? CMD_MODE_SET : CMD_ILLEGAL;
        3'b001: cmd = idle_all ? CMD_REFRESH : CMD_ILLEGAL;
        3'b110: begin
          if (idle_all) begin
            cmd = pins.addr[`SDCD_AP_BIT] ? CMD_ZQ_LONG : CMD_ZQ_SHORT;
          end
        end
        default: cmd = CMD_ILLEGAL;
      endcase
    end
  end

  // burst mode field caught from a write to the first mode register
  logic [1:0] bl_mode_q;
  always_ff @(posedge sys_clk) begin
    if (dev_rst) begin
      bl_mode_q <= 2'h0;
    end else if (cmd == CMD_MODE_SET && pins.ba == `SDCD_MR0_SEL) begin
      bl_mode_q <= pins.addr[1:0];
    end
  end

  // beats for a column command
  logic [3:0] beats;
  always_comb begin
    if (bl_mode_q == `SDCD_BL_OTF) begin
      beats = pins.addr[`SDCD_BC_BIT] ? `SDCD_BEATS_BL8 : `SDCD_BEATS_BC4;
    end else if (bl_mode_q == `SDCD_BL_BC4) begin
      beats = `SDCD_BEATS_BC4;
    end else begin
      beats = `SDCD_BEATS_BL8;
    end
  end

  // registered decode result
  always_ff @(posedge sys_clk) begin
    if (dev_rst) begin
      dec_q <= '0;
      dec_valid_q <= 1'b0;
    end else begin
      dec_valid_q <= (cmd != CMD_ILLEGAL) && (cmd != CMD_DESELECT) && (cmd != CMD_NOP);
      dec_q.cmd <= cmd;
      dec_q.bank <= pins.ba;
      dec_q.addr <= pins.addr;
      dec_q.auto_pre <= pins.addr[`SDCD_AP_BIT];
      dec_q.beats <= beats;
    end
  end

  // power state
  always_ff @(posedge sys_clk) begin
    if (dev_rst) begin
      pwr_q <= ST_NORMAL;
    end else begin
      case (cmd)
        CMD_PDOWN_ENTER: pwr_q <= ST_PDOWN;
        CMD_SELF_REF_ENTER: pwr_q <= ST_SELF_REF;
        CMD_PDOWN_EXIT: pwr_q <= ST_NORMAL;
        CMD_SELF_REF_EXIT: pwr_q <= ST_NORMAL;
        default: pwr_q <= pwr_q;
      endcase
    end
  end

  // burst framing: counts half-clock beats two per clock
  logic [3:0] beats_left_q;
  logic burst_ap_q;
  logic burst_end;
  assign burst_end = burst_busy_q && (beats_left_q <= 4'h2);
  always_ff @(posedge sys_clk) begin
    if (dev_rst) begin
      burst_busy_q <= 1'b0;
      burst_write_q <= 1'b0;
      burst_bank_q <= 3'h0;
      burst_col_q <= 10'h000;
      beats_left_q <= 4'h0;
      burst_ap_q <= 1'b0;
    end else if (cmd == CMD_READ || cmd == CMD_WRITE) begin
      burst_busy_q <= 1'b1;
      burst_write_q <= (cmd == CMD_WRITE);
      burst_bank_q <= pins.ba;
      burst_col_q <= pins.addr[`SDCD_COL_W-1:0];
      beats_left_q <= beats;
      burst_ap_q <= pins.addr[`SDCD_AP_BIT];
    end else if (burst_busy_q) begin
      beats_left_q <= beats_left_q - 4'h2;
      burst_col_q <= burst_col_q + 10'h002;
      if (burst_end) begin
        burst_busy_q <= 1'b0;
      end
    end
  end

  // per-bank open state; one generate step per bank
  genvar gb;
  generate
    for (gb = 0; gb < `SDCD_BANKS; gb++) begin : g_bank
      always_ff @(posedge sys_clk) begin
        if (dev_rst) begin
          bank_open_q[gb] <= 1'b0;
        end else if (cmd == CMD_ACTIVATE && pins.ba == 3'(gb)) begin
          bank_open_q[gb] <= 1'b1;
        end else if (cmd == CMD_PRECHARGE &&
                     (pins.addr[`SDCD_AP_BIT] || pins.ba == 3'(gb))) begin
          bank_open_q[gb] <= 1'b0;
        end else if (burst_end && burst_ap_q && burst_bank_q == 3'(gb)) begin
          bank_open_q[gb] <= 1'b0;
        end
      end
    end
  endgenerate

  // write data: low word is first half-clock, masks per byte lane
  always_ff @(posedge sys_clk) begin
    if (dev_rst) begin
      wdata_q <= 32'h0000_0000;
      wbyte_en_q <= 4'h0;
      wdata_valid_q <= 1'b0;
    end else begin
      wdata_valid_q <= burst_busy_q && burst_write_q;
      wdata_q <= wr_data_pair;
      wbyte_en_q <= {~wr_mask[1], ~wr_mask[0], ~wr_mask[1], ~wr_mask[0]};
    end
  end

  // checks
  property p_pdown_entry;
    @(posedge sys_clk) disable iff (dev_rst)
      (pwr_q == ST_NORMAL && cke_prev_q && !pins.cke && nop_or_des) |=> pwr_q == ST_PDOWN;
  endproperty
  a_pdown_entry: assert property (p_pdown_entry) else $error("power-down not entered");
  property p_pdown_exit;
    @(posedge sys_clk) disable iff (dev_rst)
      (pwr_q == ST_PDOWN && !cke_prev_q && pins.cke && nop_or_des) |=> pwr_q == ST_NORMAL;
  endproperty
  a_pdown_exit: assert property (p_pdown_exit) else $error("power-down not left");
  property p_deselect;
    @(posedge sys_clk) disable iff (dev_rst)
      (pwr_q == ST_NORMAL && cke_prev_q && pins.cke && pins.cs_n) |=> !dec_valid_q;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect produced a command");
  property p_prech_all;
    @(posedge sys_clk) disable iff (dev_rst)
      (cmd == CMD_PRECHARGE && pins.addr[`SDCD_AP_BIT]) |=> bank_open_q == 8'h00;
  endproperty
  a_prech_all: assert property (p_prech_all) else $error("all-bank precharge failed");
  property p_read_idle;
    @(posedge sys_clk) disable iff (dev_rst)
      (pwr_q == ST_NORMAL && cke_prev_q && pins.cke && !pins.cs_n && !bank_act &&
       {pins.ras_n, pins.cas_n, pins.we_n} == 3'b101 && !burst_end) |=> $stable(bank_open_q);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read to idle bank acted");
  property p_bc4_otf;
    @(posedge sys_clk) disable iff (dev_rst)
      (cmd == CMD_READ && bl_mode_q == `SDCD_BL_OTF && !pins.addr[`SDCD_BC_BIT])
      |=> burst_busy_q ##1 burst_busy_q ##1 !burst_busy_q;
  endproperty
  a_bc4_otf: assert property (p_bc4_otf) else $error("chopped burst length wrong");
  sequence s_bl8_run;
    burst_busy_q [*4] ##1 !burst_busy_q;
  endsequence
  property p_bl8_fixed;
    @(posedge sys_clk) disable iff (dev_rst)
      ((cmd == CMD_WRITE || cmd == CMD_READ) && bl_mode_q == `SDCD_BL_BL8) |=> s_bl8_run;
  endproperty
  a_bl8_fixed: assert property (p_bl8_fixed) else $error("eight-beat burst length wrong");
  property p_mask;
    @(posedge sys_clk) disable iff (dev_rst)
      wr_mask[0] |=> !wbyte_en_q[0] && !wbyte_en_q[2];
  endproperty
  a_mask: assert property (p_mask) else $error("lower byte not masked");
  property p_zq;
    @(posedge sys_clk) disable iff (dev_rst)
      (cmd == CMD_ZQ_LONG) |=> dec_valid_q && dec_q.addr[`SDCD_AP_BIT];
  endproperty
  a_zq: assert property (p_zq) else $error("long calibration not reported");
  property p_act_open;
    @(posedge sys_clk) disable iff (dev_rst)
      (pwr_q == ST_NORMAL && cke_prev_q && pins.cke && !pins.cs_n && bank_act &&
       {pins.ras_n, pins.cas_n, pins.we_n} == 3'b011) |=> !dec_valid_q;
  endproperty
  a_act_open: assert property (p_act_open) else $error("activate to open bank acted");
  property p_mrs_busy;
    @(posedge sys_clk) disable iff (dev_rst)
      (pwr_q == ST_NORMAL && cke_prev_q && pins.cke && !pins.cs_n && !idle_all &&
       {pins.ras_n, pins.cas_n, pins.we_n} == 3'b000) |=> !dec_valid_q && $stable(bl_mode_q);
  endproperty
  a_mrs_busy: assert property (p_mrs_busy) else $error("mode write with open bank acted");
  property p_cke_prior;
    @(posedge sys_clk) disable iff (dev_rst)
      (pwr_q == ST_NORMAL && !cke_prev_q && pins.cke) |=> !dec_valid_q;
  endproperty
  a_cke_prior: assert property (p_cke_prior) else $error("command taken without prior cke");
  property p_upper_mask;
    @(posedge sys_clk) disable iff (dev_rst)
      wr_mask[1] |=> !wbyte_en_q[1] && !wbyte_en_q[3];
  endproperty
  a_upper_mask: assert property (p_upper_mask) else $error("upper byte not masked");
  property p_auto_pre;
    @(posedge sys_clk) disable iff (dev_rst)
      (burst_end && burst_ap_q && cmd != CMD_ACTIVATE && cmd != CMD_READ && cmd != CMD_WRITE)
      |=> !bank_open_q[burst_bank_q];
  endproperty
  a_auto_pre: assert property (p_auto_pre) else $error("auto-precharge left bank open");
  property p_pin_reset;
    @(posedge sys_clk) disable iff (reset)
      rst_hold_q |=> bank_open_q == 8'h00 && !burst_busy_q && !dec_valid_q;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset did not clear state");
endmodule : sdcd_decoder
`default_nettype wire

// *** sdcd_ctl_model.sv ***
// controller model that encodes command requests onto the decoder's command pins
`timescale 1ns/10ps
`default_nettype none
module sdcd_ctl_model
  import sdcd_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire sdcd_cmd_type req_cmd, // command to put on the pins
  input wire logic [2:0] req_ba, // bank lines
  input wire logic [12:0] req_addr, // row, column or op code
  input wire logic req_cke, // clock enable level
  output sdcd_pins_type pins // command pins
);
  logic [15:0] junk_q = 16'h0000;

  // filler that changes every cycle for lines that carry no meaning
  always_ff @(posedge sys_clk) begin
    junk_q <= junk_q + 16'h1357;
  end

  // strobe encoding per command, changed just after the edge by the bench
  always_comb begin
    pins.cs_n = 1'b0;
    pins.cke = req_cke;
    pins.ba = req_ba;
    pins.addr = req_addr;
    {pins.ras_n, pins.cas_n, pins.we_n} = 3'h7;
    case (req_cmd)
      CMD_DESELECT: begin
        pins.cs_n = 1'b1;
        {pins.ras_n, pins.cas_n, pins.we_n} = junk_q[2:0];
        pins.ba = junk_q[5:3];
        pins.addr = junk_q[15:3];
      end
      CMD_ACTIVATE: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h3;
      CMD_PRECHARGE: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h2;
      CMD_WRITE: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h4;
      CMD_READ: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h5;
      CMD_MODE_SET: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h0;
      CMD_REFRESH, CMD_SELF_REF_ENTER: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h1;
      CMD_ZQ_LONG, CMD_ZQ_SHORT: begin
        {pins.ras_n, pins.cas_n, pins.we_n} = 3'h6;
        pins.ba = junk_q[2:0];
      end
      default: ;
    endcase
  end
endmodule : sdcd_ctl_model
`default_nettype wire

// *** sdram_command_decoder_tb_top.sv ***
// self-checking bench for the sdram command decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("unexpected %s expected %0h seen %0h", what, exp, got); \
  end \
end
module sdram_command_decoder_tb_top;
  import sdcd_pkg::*;
  typedef struct {
    sdcd_cmd_type cmd;
    logic [2:0] ba;
    logic [12:0] addr;
    logic vld;
    logic [3:0] beats;
    logic [7:0] open;
  } sdcd_tb_row_type;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reset_pin_n = 1'b1;
  logic [1:0] wr_mask = 2'h0;
  logic [31:0] wr_data_pair = 32'ha1b2_c3d4;
  sdcd_cmd_type req_cmd = CMD_DESELECT;
  logic [2:0] req_ba = 3'h0;
  logic [12:0] req_addr = 13'h0000;
  logic req_cke = 1'b1;
  sdcd_pins_type pins;
  sdcd_dec_type dec_q;
  sdcd_pwr_type pwr_q;
  logic dec_valid_q, burst_busy_q, burst_write_q, wdata_valid_q;
  logic [7:0] bank_open_q;
  logic [2:0] burst_bank_q;
  logic [9:0] burst_col_q;
  logic [31:0] wdata_q, bm;
  logic [3:0] wbyte_en_q, en;
  logic [1:0] m;
  int fails = 0;
  int comparisons = 0;
  // steps in order, each with the answer and the bank state it leaves
  sdcd_tb_row_type rows [26] = '{
    '{CMD_MODE_SET, 3'h0, 13'h0001, 1'b1, 4'h0, 8'h00},
    '{CMD_ACTIVATE, 3'h1, 13'h0123, 1'b1, 4'h0, 8'h02},
    '{CMD_ACTIVATE, 3'h1, 13'h0123, 1'b0, 4'h0, 8'h02},
    '{CMD_READ, 3'h2, 13'h0010, 1'b0, 4'h0, 8'h02},
    '{CMD_READ, 3'h1, 13'h0010, 1'b1, 4'h4, 8'h02},
    '{CMD_WRITE, 3'h1, 13'h1020, 1'b1, 4'h8, 8'h02},
    '{CMD_WRITE, 3'h1, 13'h0020, 1'b1, 4'h4, 8'h02},
    '{CMD_PRECHARGE, 3'h1, 13'h0000, 1'b1, 4'h0, 8'h00},
    '{CMD_ACTIVATE, 3'h3, 13'h0001, 1'b1, 4'h0, 8'h08},
    '{CMD_ACTIVATE, 3'h2, 13'h0001, 1'b1, 4'h0, 8'h0c},
    '{CMD_MODE_SET, 3'h0, 13'h0000, 1'b0, 4'h0, 8'h0c},
    '{CMD_REFRESH, 3'h0, 13'h0000, 1'b0, 4'h0, 8'h0c},
    '{CMD_PRECHARGE, 3'h0, 13'h0400, 1'b1, 4'h0, 8'h00},
    '{CMD_REFRESH, 3'h0, 13'h0000, 1'b1, 4'h0, 8'h00},
    '{CMD_NOP, 3'h0, 13'h0000, 1'b0, 4'h0, 8'h00},
    '{CMD_DESELECT, 3'h0, 13'h0000, 1'b0, 4'h0, 8'h00},
    '{CMD_ZQ_LONG, 3'h0, 13'h0400, 1'b1, 4'h0, 8'h00},
    '{CMD_ZQ_SHORT, 3'h0, 13'h0000, 1'b1, 4'h0, 8'h00},
    '{CMD_MODE_SET, 3'h0, 13'h0000, 1'b1, 4'h0, 8'h00},
    '{CMD_ACTIVATE, 3'h6, 13'h0001, 1'b1, 4'h0, 8'h40},
    '{CMD_READ, 3'h6, 13'h0008, 1'b1, 4'h8, 8'h40},
    '{CMD_READ, 3'h6, 13'h0408, 1'b1, 4'h8, 8'h00},
    '{CMD_WRITE, 3'h6, 13'h1000, 1'b0, 4'h0, 8'h00},
    '{CMD_MODE_SET, 3'h0, 13'h0002, 1'b1, 4'h0, 8'h00},
    '{CMD_ACTIVATE, 3'h4, 13'h0055, 1'b1, 4'h0, 8'h10},
    '{CMD_READ, 3'h4, 13'h1010, 1'b1, 4'h4, 8'h10}
  };

  // clock
  always #2 sys_clk = ~sys_clk;

  sdcd_ctl_model sdcd_ctl_model_i (.sys_clk(sys_clk), .req_cmd(req_cmd), .req_ba(req_ba),
    .req_addr(req_addr), .req_cke(req_cke), .pins(pins));
  sdcd_decoder sdcd_decoder_i (.sys_clk(sys_clk), .reset(reset), .reset_pin_n(reset_pin_n),
    .pins(pins), .wr_mask(wr_mask), .wr_data_pair(wr_data_pair), .dec_q(dec_q),
    .dec_valid_q(dec_valid_q), .bank_open_q(bank_open_q), .pwr_q(pwr_q),
    .burst_busy_q(burst_busy_q), .burst_write_q(burst_write_q), .burst_bank_q(burst_bank_q),
    .burst_col_q(burst_col_q), .wdata_q(wdata_q), .wbyte_en_q(wbyte_en_q),
    .wdata_valid_q(wdata_valid_q));

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // one command for one cycle, then deselect; returns once the answer has settled
  task automatic drive(input sdcd_cmd_type c, input logic [2:0] b, input logic [12:0] a);
    @(posedge sys_clk);
    req_cmd <= c;
    req_ba <= b;
    req_addr <= a;
    @(posedge sys_clk);
    req_cmd <= CMD_DESELECT;
    #1;
  endtask : drive

  // cut a hang short
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    end_sim();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    // pin synchroniser and prior-cke flop need a few clocks after reset
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK("reset open", 8'h00, bank_open_q)
    `CHK("reset pwr", ST_NORMAL, pwr_q)
    foreach (rows[i]) begin
      drive(rows[i].cmd, rows[i].ba, rows[i].addr);
      `CHK("valid", rows[i].vld, dec_valid_q)
      if (rows[i].vld) begin
        `CHK("cmd", rows[i].cmd, dec_q.cmd)
        `CHK("addr", rows[i].addr, dec_q.addr)
      end
      if (rows[i].beats != 4'h0) begin
        `CHK("bank", rows[i].ba, dec_q.bank)
        `CHK("beats", rows[i].beats, dec_q.beats)
        `CHK("auto_pre", rows[i].addr[10], dec_q.auto_pre)
      end
      repeat (8) @(posedge sys_clk);
      #1;
      `CHK("bank_open", rows[i].open, bank_open_q)
    end
    // masked writes to open bank 4, one byte lane masked each time
    for (int n = 0; n < 2; n++) begin
      m = n[0] ? 2'h2 : 2'h1;
      en = {~m[1], ~m[0], ~m[1], ~m[0]};
      bm = {{8{en[3]}}, {8{en[2]}}, {8{en[1]}}, {8{en[0]}}};
      @(posedge sys_clk);
      wr_mask <= m;
      drive(CMD_WRITE, 3'h4, 13'h0010);
      for (int k = 0; k < 4 && burst_busy_q !== 1'b1; k++) begin
        @(posedge sys_clk);
        #1;
      end
      `CHK("burst busy", 1'b1, burst_busy_q)
      `CHK("burst col", 10'h010, burst_col_q)
      `CHK("burst bank", 3'h4, burst_bank_q)
      `CHK("burst write", 1'b1, burst_write_q)
      @(posedge sys_clk);
      #1;
      `CHK("burst step", 10'h012, burst_col_q)
      for (int k = 0; k < 4 && wdata_valid_q !== 1'b1; k++) begin
        @(posedge sys_clk);
        #1;
      end
      `CHK("wdata valid", 1'b1, wdata_valid_q)
      `CHK("byte enables", en, wbyte_en_q)
      `CHK("write data", wr_data_pair & bm, wdata_q & bm)
      repeat (6) @(posedge sys_clk);
    end
    drive(CMD_PRECHARGE, 3'h0, 13'h0400);
    // power-down entry on cke fall, commands refused inside, exit on cke rise
    @(posedge sys_clk);
    req_cke <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("pdown", ST_PDOWN, pwr_q)
    drive(CMD_ACTIVATE, 3'h0, 13'h0001);
    `CHK("pdown refuse", 1'b0, dec_valid_q)
    @(posedge sys_clk);
    req_cke <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("pdown exit", ST_NORMAL, pwr_q)
    // self-refresh entry and exit
    @(posedge sys_clk);
    req_cmd <= CMD_SELF_REF_ENTER;
    req_cke <= 1'b0;
    @(posedge sys_clk);
    req_cmd <= CMD_DESELECT;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("self ref", ST_SELF_REF, pwr_q)
    @(posedge sys_clk);
    req_cke <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("self ref exit", ST_NORMAL, pwr_q)
    // device reset pin clears banks and blocks commands while low
    drive(CMD_ACTIVATE, 3'h7, 13'h0001);
    @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK("pin reset open", 8'h00, bank_open_q)
    drive(CMD_ACTIVATE, 3'h7, 13'h0001);
    `CHK("pin reset refuse", 1'b0, dec_valid_q)
    @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    drive(CMD_ACTIVATE, 3'h7, 13'h0001);
    `CHK("after pin reset", 1'b1, dec_valid_q)
    `CHK("after pin reset open", 8'h80, bank_open_q)
    end_sim();
  end
endmodule : sdram_command_decoder_tb_top
`default_nettype wire
